//--- core/tile_core_config_status_regs.sv
// AHB-Lite register bank for core status, cache configuration and thermal sensor
//
// Our own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "tile_config_defines.svh"

module tile_core_config_status_regs (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire tile_config_pkg::cycle_evt_s cycle_evt,
   input wire tile_config_pkg::core_lines_s core_lines,
   output logic gate_cache_ctrl_clock,
   output logic gate_cache_array_clock,
   output logic bitline_float_en,
   output logic wordline_sleep_en,
   output logic write_driver_sleep_en,
   output logic data_ecc_en,
   output logic tag_ecc_en,
   output logic sleep_bypass,
   output logic cache_disable,
   output logic [3:0] array_sleep_level,
   output logic sensor_enable,
   output logic [12:0] thermal_gate_count
);

   //------------------------------------------------------------
   // bus slave
   //------------------------------------------------------------
   tile_config_pkg::phase_e phase_r, phase_nxt; // pending data phase
   logic [11:0] addr_r, addr_nxt; // latched address
   logic [31:0] rdata_r, rdata_nxt; // read data register
   logic hreadyout_r, hreadyout_nxt; // ready flop; this slave never stretches a transfer
   logic hresp_r, hresp_nxt; // response flop; every transfer ends okay

   // sticky status and register contents
   logic [5:0] sticky_r, sticky_nxt; // status bits 17:12
   logic fp_err_r, fp_err_nxt; // captured fp error, active low
   logic int_err_r, int_err_nxt; // captured internal error, active low
   logic [13:0] cache_r, cache_nxt; // cache configuration
   logic [13:0] sensor_r, sensor_nxt; // thermal sensor control

   logic addr_take; // valid address phase
   logic wr_status; // data phase of a status write
   logic wr_cache;
   logic wr_sensor;
   logic [5:0] evt_vec; // packed cycle events

   // read mux, used only in the read address phase
   function automatic logic [31:0] read_word(input logic [11:0] a,
         input logic [5:0] st, input logic fe, input logic ie,
         input tile_config_pkg::core_lines_s cl, input logic [13:0] cc,
         input logic [13:0] sn);
      logic [31:0] w;
      w = 32'h0000_0000;
      // address decode of the three words
      if (a == `OFF_STATUS) begin
         w[`ST_SHUTDOWN:`ST_BRANCH] = st;
         w[`ST_MGMT] = cl.mgmt_mode_active_n;
         w[`ST_PROBE] = cl.probe_ready;
         w[`ST_FP_ERR] = fe;
         w[`ST_INT_ERR] = ie;
         // the core itself picks breakpoint or perf counter on bits 0 and 1
         w[`ST_DBG_LO+3:`ST_DBG_LO] = cl.debug_event_bits;
      end else if (a == `OFF_CACHE) begin
         w[13:0] = cc;
      end else if (a == `OFF_SENSOR) begin
         w[13:0] = sn;
      end
      // any other word falls through and reads as zero
      return w;
   endfunction

   // a transfer is taken only when selected, ready and not idle
   assign addr_take = hsel && hready && htrans[1];
   assign wr_status = (phase_r == tile_config_pkg::PH_WRITE) && (addr_r == `OFF_STATUS);
   assign wr_cache = (phase_r == tile_config_pkg::PH_WRITE) && (addr_r == `OFF_CACHE);
   assign wr_sensor = (phase_r == tile_config_pkg::PH_WRITE) && (addr_r == `OFF_SENSOR);
   // packed special cycle strobes, branch trace in bit 0
   assign evt_vec = {cycle_evt.shutdown, cycle_evt.cache_flush, cycle_evt.stop,
                     cycle_evt.writeback, cycle_evt.flush_ack, cycle_evt.branch_trace};

   // next state of the bus phase, address and read data
   always_comb begin
      phase_nxt = tile_config_pkg::PH_IDLE;
      addr_nxt = addr_r;
      rdata_nxt = rdata_r;
      // no wait states and no error response: the bus never stalls on this bank
      hreadyout_nxt = 1'b1;
      hresp_nxt = 1'b0;
      if (addr_take) begin
         // unmapped addresses still answer okay, reading zero; sub-word addresses align down to their word
         addr_nxt = {haddr[11:2], 2'b00};
         // writes wait for the data phase before touching any register
         if (hwrite) begin
            phase_nxt = tile_config_pkg::PH_WRITE;
         end else begin
            phase_nxt = tile_config_pkg::PH_READ;
            // sample in the address phase so data stands in the next cycle
            rdata_nxt = read_word({haddr[11:2], 2'b00}, sticky_r, fp_err_r, int_err_r,
                                  core_lines, cache_r, sensor_r);
         end
      end
   end

   // bus slave registers only; ready and response also come from flops
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         phase_r <= tile_config_pkg::PH_IDLE;
         addr_r <= 12'h000;
         rdata_r <= 32'h0000_0000; // hrdata stays zero after reset until the first read
         hreadyout_r <= 1'b1; // ready from the first reset edge
         hresp_r <= 1'b0;
      end else begin
         phase_r <= phase_nxt;
         addr_r <= addr_nxt;
         rdata_r <= rdata_nxt;
         hreadyout_r <= hreadyout_nxt;
         hresp_r <= hresp_nxt;
      end
   end

   //------------------------------------------------------------
   // register contents
   //------------------------------------------------------------
   // a status write clears, but a same-cycle event sets anyway
   always_comb begin
      sticky_nxt = sticky_r;
      fp_err_nxt = fp_err_r;
      int_err_nxt = int_err_r;
      cache_nxt = cache_r;
      sensor_nxt = sensor_r;
      // a write to the status word clears whatever it carries
      if (wr_status) begin
         sticky_nxt = 6'h00;
         fp_err_nxt = 1'b1;
         int_err_nxt = 1'b1;
      end
      // set wins: the or comes after the clear, so no event is lost
      sticky_nxt = sticky_nxt | evt_vec;
      // error lines are active low; a low level captures again every cycle
      if (!core_lines.fp_error_n) begin
         fp_err_nxt = 1'b0;
      end
      if (!core_lines.internal_error_n) begin
         int_err_nxt = 1'b0;
      end
      // configuration writes land at the end of the data phase
      if (wr_cache) begin
         // bit 8 is not writable
         cache_nxt = hwdata[13:0] & `CACHE_WMASK;
      end
      // every sensor bit is writable
      if (wr_sensor) begin
         sensor_nxt = hwdata[13:0];
      end
   end

   // sticky status and configuration registers only
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         sticky_r <= 6'h00;
         fp_err_r <= 1'b1;
         int_err_r <= 1'b1;
         cache_r <= `CACHE_RESET;
         sensor_r <= `SENSOR_RESET;
      end else begin
         sticky_r <= sticky_nxt;
         fp_err_r <= fp_err_nxt;
         int_err_r <= int_err_nxt;
         cache_r <= cache_nxt;
         sensor_r <= sensor_nxt;
      end
   end

   //------------------------------------------------------------
   // outputs, all straight from flip-flops
   //------------------------------------------------------------
   assign hrdata = rdata_r;
   assign hreadyout = hreadyout_r; // zero wait states
   assign hresp = hresp_r; // always okay
   // the cache and sensor outputs are plain register bits
   assign gate_cache_ctrl_clock = cache_r[13];
   assign gate_cache_array_clock = cache_r[12];
   assign bitline_float_en = cache_r[11];
   assign wordline_sleep_en = cache_r[10];
   assign write_driver_sleep_en = cache_r[9];
   assign data_ecc_en = cache_r[7];
   assign tag_ecc_en = cache_r[6];
   assign sleep_bypass = cache_r[5];
   assign cache_disable = cache_r[`CACHE_DISABLE_BIT];
   assign array_sleep_level = cache_r[3:0];
   assign sensor_enable = sensor_r[`SENSOR_EN_BIT];
   assign thermal_gate_count = sensor_r[12:0];

   //------------------------------------------------------------
   // assertions
   //------------------------------------------------------------
   // every property samples on the tile clock and rests while reset is low, except a_cache_reset, which runs during reset
   // a read address phase aimed at the status word
   sequence s_status_read;
      addr_take && !hwrite && ({haddr[11:2], 2'b00} == `OFF_STATUS);
   endsequence

   // an fp error followed by a cycle with no clearing write
   sequence s_fp_err_kept;
      !core_lines.fp_error_n ##1 !wr_status;
   endsequence

   // an internal error followed by a cycle with no clearing write
   sequence s_int_err_kept;
      !core_lines.internal_error_n ##1 !wr_status;
   endsequence

   // each special cycle strobe lands in its own sticky bit one edge later
   a_event_sets_bit: assert property (@(posedge ref_clk) disable iff (!resetn)
      cycle_evt.branch_trace |=> sticky_r[0])
      else $error("branch trace event not captured");
   a_flush_ack_sets: assert property (@(posedge ref_clk) disable iff (!resetn)
      cycle_evt.flush_ack |=> sticky_r[1])
      else $error("flush acknowledge not captured");
   a_writeback_sets: assert property (@(posedge ref_clk) disable iff (!resetn)
      cycle_evt.writeback |=> sticky_r[2])
      else $error("write back not captured");
   a_stop_sets: assert property (@(posedge ref_clk) disable iff (!resetn)
      cycle_evt.stop |=> sticky_r[3])
      else $error("stop cycle not captured");
   a_flush_sets: assert property (@(posedge ref_clk) disable iff (!resetn)
      cycle_evt.cache_flush |=> sticky_r[4])
      else $error("cache flush not captured");
   a_shutdown_sets: assert property (@(posedge ref_clk) disable iff (!resetn)
      cycle_evt.shutdown |=> sticky_r[5])
      else $error("shutdown event not captured");

   // sticky bits only fall on a clearing write
   a_sticky_holds: assert property (@(posedge ref_clk) disable iff (!resetn)
      !wr_status |=> (sticky_r & $past(sticky_r)) == $past(sticky_r))
      else $error("sticky bit dropped without a write");

   // live lines reach the word sampled in the read address phase
   a_mgmt_live_read: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_status_read |=> hrdata[`ST_MGMT] == $past(core_lines.mgmt_mode_active_n))
      else $error("management bit not live");
   a_probe_live_read: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_status_read |=> hrdata[`ST_PROBE] == $past(core_lines.probe_ready))
      else $error("probe bit not live");
   a_debug_read: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_status_read |=> hrdata[25:22] == $past(core_lines.debug_event_bits))
      else $error("debug bits wrong");

   // error captures are active low and hold until cleared
   a_fp_err_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_fp_err_kept |=> !fp_err_r)
      else $error("fp error not held");
   a_int_err_cap: assert property (@(posedge ref_clk) disable iff (!resetn)
      !core_lines.internal_error_n |=> !int_err_r)
      else $error("internal error not captured");
   a_int_err_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_int_err_kept |=> !int_err_r)
      else $error("internal error not held");

   // a status write clears, but an event in the same cycle survives
   a_clear_all: assert property (@(posedge ref_clk) disable iff (!resetn)
      wr_status && evt_vec == 6'h00 |=> sticky_r == 6'h00)
      else $error("status write did not clear");
   a_err_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
      wr_status && core_lines.fp_error_n && core_lines.internal_error_n |=> fp_err_r && int_err_r)
      else $error("status write did not clear errors");
   a_set_beats_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
      wr_status && cycle_evt.stop |=> sticky_r[3])
      else $error("event lost on clear");

   // bits with no function read zero
   a_unused_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
      (cache_r[8] == 1'b0) and (s_status_read |=> hrdata[31:26] == 6'h00))
      else $error("unused bits not zero");
   a_status_low_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_status_read |=> hrdata[11:0] == 12'h000)
      else $error("low status bits not zero");

   // configuration writes appear on the outputs one edge later
   a_cache_write: assert property (@(posedge ref_clk) disable iff (!resetn)
      wr_cache |=> cache_disable == $past(hwdata[4])
         && array_sleep_level == $past(hwdata[3:0]))
      else $error("cache write not applied");
   a_cache_ctrl_bits: assert property (@(posedge ref_clk) disable iff (!resetn)
      wr_cache |=> {gate_cache_ctrl_clock, gate_cache_array_clock, bitline_float_en,
         wordline_sleep_en, write_driver_sleep_en} == $past(hwdata[13:9]))
      else $error("cache control bits not applied");
   a_sensor_write: assert property (@(posedge ref_clk) disable iff (!resetn)
      wr_sensor |=> sensor_enable == $past(hwdata[13])
         && thermal_gate_count == $past(hwdata[12:0]))
      else $error("sensor write not applied");

   // reset leaves the cache register at its reset value
   a_cache_reset: assert property (@(posedge ref_clk)
      !resetn |=> cache_r == `CACHE_RESET)
      else $error("cache reset value wrong");

endmodule
`default_nettype wire

//--- core/tile_config_defines.svh
// register offsets, field positions and reset values for the tile configuration bank
//------------------------------------------------------------
// Summary of operation
// - special cycles set sticky bits 12, 13, 14
// - stop, flush, shutdown cycles set bits 15-17
// - bit 18 follows management mode output live
// - bit 19 follows probe ready output live
// - bit 20 captures fp error, active low
// - bit 21 captures internal error, active low
// - bits 25:22 show four debug event outputs
// - low debug bits selected by core, reset perf
// - cache bits 13, 12 gate clocks, reset zero
// - cache bits 11, 10, 9 reset 0, 1, 1
// - cache bit 4 disables cache, reset zero
// - cache bits 3:0 sleep level, reset 1111
// - sensor enable bit 13, gate count 12:0
// - any status write clears all sticky bits
// - new event wins over same-cycle clear
//------------------------------------------------------------
`ifndef TILE_CONFIG_DEFINES_SVH
`define TILE_CONFIG_DEFINES_SVH

// byte offsets of the three registers
`define OFF_STATUS 12'h000
`define OFF_CACHE 12'h004
`define OFF_SENSOR 12'h008

// status field positions
`define ST_BRANCH 12
`define ST_FLUSH_ACK 13
`define ST_WRITEBACK 14
`define ST_STOP 15
`define ST_CACHE_FLUSH 16
`define ST_SHUTDOWN 17
`define ST_MGMT 18
`define ST_PROBE 19
`define ST_FP_ERR 20
`define ST_INT_ERR 21
`define ST_DBG_LO 22

// cache configuration: writable bits and reset value
`define CACHE_WMASK 14'h3EFF
`define CACHE_RESET 14'h06CF
`define CACHE_DISABLE_BIT 4

// sensor fields
`define SENSOR_EN_BIT 13
`define SENSOR_RESET 14'h0000

`endif

//--- core/tile_config_pkg.sv
// types shared by the tile configuration bank
package tile_config_pkg;
   // special cycle strobes from the core, one cycle each
   typedef struct packed {
      logic branch_trace;
      logic flush_ack;
      logic writeback;
      logic stop;
      logic cache_flush;
      logic shutdown;
   } cycle_evt_s;
   // live status lines from the core
   typedef struct packed {
      logic mgmt_mode_active_n;
      logic probe_ready;
      logic fp_error_n;
      logic internal_error_n;
      logic [3:0] debug_event_bits;
   } core_lines_s;
   // data phase state of the bus slave
   typedef enum logic [1:0] {PH_IDLE, PH_WRITE, PH_READ} phase_e;
endpackage

//--- verif/core_stub.sv
// model of the core's special-cycle strobes and live status lines
`timescale 1ns/1ps
`default_nettype none
module core_stub (
   input wire logic ref_clk,
   input wire logic [5:0] ev_in,
   input wire logic [7:0] ln_in,
   output var tile_config_pkg::cycle_evt_s cycle_evt,
   output var tile_config_pkg::core_lines_s core_lines
);
   // the core launches strobes and levels just after its clock edge, like real flops
   always_ff @(posedge ref_clk) begin
      cycle_evt <= ev_in;
      core_lines <= ln_in;
   end
endmodule
`default_nettype wire

//--- verif/tb.sv
// self-checking testbench for the tile configuration bank
`timescale 1ns/1ps
`default_nettype none
`include "tile_config_defines.svh"
module tb;
   logic ref_clk = 0, resetn = 0, hsel = 0, hwrite = 0, pend_w = 0;
   logic [11:0] haddr = 0, pend_a = 0;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 0, hrdata;
   logic hreadyout, hresp, g_cc, g_ca, bl, wl, wd, de, te, sb, cd, se;
   logic [3:0] asl;
   logic [12:0] tgc;
   logic [5:0] ev_in = 0, st_m;
   logic [7:0] ln_in = 8'hB0;
   logic fe_m, ie_m;
   logic [13:0] cache_m, sensor_m;
   tile_config_pkg::cycle_evt_s cycle_evt;
   tile_config_pkg::core_lines_s core_lines;
   integer n_errors = 0, tests_run = 0, seed = 32'h9836D709, i;
   always #2 ref_clk = ~ref_clk;
   core_stub u_core_stub (.ref_clk(ref_clk), .ev_in(ev_in), .ln_in(ln_in),
      .cycle_evt(cycle_evt), .core_lines(core_lines));
   tile_core_config_status_regs u_tile_core_config_status_regs (.ref_clk(ref_clk),
      .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .cycle_evt(cycle_evt), .core_lines(core_lines),
      .gate_cache_ctrl_clock(g_cc), .gate_cache_array_clock(g_ca), .bitline_float_en(bl),
      .wordline_sleep_en(wl), .write_driver_sleep_en(wd), .data_ecc_en(de), .tag_ecc_en(te),
      .sleep_bypass(sb), .cache_disable(cd), .array_sleep_level(asl), .sensor_enable(se),
      .thermal_gate_count(tgc));
   //------------------------------------------------------------
   // reference model: a clear and a same-cycle event give the event
   //------------------------------------------------------------
   always @(posedge ref_clk) begin
      if (!resetn) begin
         st_m <= 6'h00;
         fe_m <= 1'b1;
         ie_m <= 1'b1;
         cache_m <= `CACHE_RESET;
         sensor_m <= `SENSOR_RESET;
      end else begin
         // event bits reversed so index 0 is the lowest status position
         st_m <= ((pend_w && pend_a == `OFF_STATUS) ? 6'h00 : st_m) | {cycle_evt.shutdown,
            cycle_evt.cache_flush, cycle_evt.stop, cycle_evt.writeback, cycle_evt.flush_ack,
            cycle_evt.branch_trace};
         fe_m <= ((pend_w && pend_a == `OFF_STATUS) ? 1'b1 : fe_m) & core_lines.fp_error_n;
         ie_m <= ((pend_w && pend_a == `OFF_STATUS) ? 1'b1 : ie_m) & core_lines.internal_error_n;
         if (pend_w && pend_a == `OFF_CACHE) begin
            cache_m <= (hwdata[13:0] & `CACHE_WMASK) | (cache_m & ~`CACHE_WMASK);
         end
         if (pend_w && pend_a == `OFF_SENSOR) begin
            sensor_m <= hwdata[13:0];
         end
      end
   end
   // word the model expects for a read whose address phase is this edge
   function logic [31:0] rd_model(input logic [11:0] a);
      case (a)
         `OFF_STATUS: rd_model = {6'h00, core_lines.debug_event_bits, ie_m, fe_m,
            core_lines.probe_ready, core_lines.mgmt_mode_active_n, st_m, 12'h000};
         `OFF_CACHE: rd_model = {18'h00000, cache_m};
         `OFF_SENSOR: rd_model = {18'h00000, sensor_m};
         default: rd_model = 32'h00000000;
      endcase
   endfunction
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (exp !== got) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one single-word transfer; read data is compared with the model
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      logic [31:0] e;
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      e = rd_model(a);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      pend_w <= w;
      pend_a <= a;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      pend_w <= 1'b0;
      chk("hresp", 32'h0, {31'h0, hresp});
      if (!w) chk("hrdata", e, hrdata);
   endtask
   task conclude;
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // sparse random strobes; error lines mostly idle high
   always @(posedge ref_clk) begin
      ev_in <= $random(seed) & $random(seed) & $random(seed);
      ln_in <= ($random(seed) & 8'hCF) | (($random(seed) | $random(seed)) & 8'h30);
   end
   initial begin
      #40000;
      n_errors++;
      conclude;
   end
   //------------------------------------------------------------
   // main sequence
   //------------------------------------------------------------
   initial begin
      repeat (2) @(posedge ref_clk);
      resetn <= 1'b1;
      @(posedge ref_clk);
      for (i = 0; i < 4; i++) begin
         xfer(1'b0, 12'(i * 4), 32'h0);
      end
      xfer(1'b1, `OFF_CACHE, 32'hFFFFFFFF);
      xfer(1'b0, `OFF_CACHE, 32'h0);
      for (i = 0; i < 300; i++) begin
         xfer(1'($random(seed)), 12'(($random(seed) & 3) * 4),
            $random(seed));
         #1;
         chk("cache_out", 32'(cache_m),
            32'({g_cc, g_ca, bl, wl, wd, 1'b0, de, te, sb, cd, asl}));
         chk("sensor_out", 32'(sensor_m), 32'({se, tgc}));
      end
      conclude;
   end
endmodule
`default_nettype wire
